// [logic/wvrs_cfg.svh]
/*
 Constants for the wide vector register state block: sizes, alignment
 checks, reset values and the legacy transition penalty.
 Assumes inclusion by bare name from every file that needs a constant.
*/
// Notes on behaviour
// (RULE_01) The low 128 bits of each wide register are the narrow register.
// (RULE_02) A 256-bit length instruction writes all 256 destination bits.
// (RULE_03) An extended 128-bit instruction writes the low half, zeroes above.
// (RULE_04) A legacy 128-bit instruction writes the low half, keeps above.
// (RULE_05) Sixteen registers exist in 64-bit mode, only eight otherwise.
// (RULE_06) Aligned 256-bit moves fault unless the address is 32-byte aligned.
// (RULE_07) Extended load-op instructions take any address without a check.
// (RULE_08) Legacy memory forms and 128-bit aligned moves need 16 bytes.
// (RULE_09) Extended forms use a separate destination, legacy reuse source 1.
// (RULE_10) A 256-bit divide or square root runs as two 128-bit passes.
// (RULE_11) Only a legacy instruction after 256-bit code pays a penalty.
// (RULE_12) After reset every register bit reads as zero.
`ifndef WVRS_CFG_SVH
`define WVRS_CFG_SVH
`define WVRS_VEC_W      256
`define WVRS_HALF_W     128
`define WVRS_NREG       16
`define WVRS_NREG_NARROW 8
`define WVRS_IDX_W      4
`define WVRS_WIDE_LSB   5
`define WVRS_NARROW_LSB 4
`define WVRS_PEN_CYC    4'h4
`define WVRS_REG_RST    256'h0
`endif

// [logic/wvrs_div_if.sv]
/*
 Link between the register state top and its divide sequencer.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface wvrs_div_if;
   logic              start;
   logic              two_pass;
   wvrs_pkg::wvrs_vec_t opnd_a;
   wvrs_pkg::wvrs_vec_t opnd_b;
   logic              done;
   wvrs_pkg::wvrs_vec_t result;
   modport ctl (output start, two_pass, opnd_a, opnd_b, input done, result);
   modport seq (input start, two_pass, opnd_a, opnd_b, output done, result);
endinterface : wvrs_div_if

// [logic/wvrs_div_seq.sv]
/*
 Divide and square-root sequencer: splits an operation over the shared
 128-bit unit, low half first, high half second when two passes are asked.
 Assumes the 128-bit unit answers each request with a one-cycle done.
*/
`timescale 1ns/1ps
`include "wvrs_cfg.svh"
module wvrs_div_seq (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // Control side
   wvrs_div_if.seq                       ctl,
   // Shared 128-bit unit
   output logic                          dp_valid,
   output logic [`WVRS_HALF_W-1:0]       dp_a,
   output logic [`WVRS_HALF_W-1:0]       dp_b,
   input  wire logic                     dp_done,
   input  wire logic [`WVRS_HALF_W-1:0]  dp_res
);
   typedef struct packed {
      wvrs_pkg::wvrs_seq_t st;
      logic                two;
      wvrs_pkg::wvrs_vec_t a;
      wvrs_pkg::wvrs_vec_t b;
      wvrs_pkg::wvrs_vec_t res;
      logic                done;
   } wvrs_seq_state_t;

   wvrs_seq_state_t cur_ff;
   wvrs_seq_state_t nxt_cur;

   // Operand half follows the pass
   assign dp_valid    = (cur_ff.st != wvrs_pkg::sq_idle);
   assign dp_a        = (cur_ff.st == wvrs_pkg::sq_hi) ?
                        cur_ff.a[`WVRS_VEC_W-1:`WVRS_HALF_W] :
                        cur_ff.a[`WVRS_HALF_W-1:0];
   assign dp_b        = (cur_ff.st == wvrs_pkg::sq_hi) ?
                        cur_ff.b[`WVRS_VEC_W-1:`WVRS_HALF_W] :
                        cur_ff.b[`WVRS_HALF_W-1:0];
   assign ctl.done    = cur_ff.done;
   assign ctl.result  = cur_ff.res;

   // Pass sequencing
   always_comb begin
      nxt_cur      = cur_ff;
      nxt_cur.done = 1'b0;
      unique case (cur_ff.st)
         wvrs_pkg::sq_idle: begin
            if (ctl.start) begin
               nxt_cur.st  = wvrs_pkg::sq_lo;
               nxt_cur.two = ctl.two_pass;
               nxt_cur.a   = ctl.opnd_a;
               nxt_cur.b   = ctl.opnd_b;
               nxt_cur.res = `WVRS_REG_RST;
            end
         end
         // (RULE_10) low half first
         wvrs_pkg::sq_lo: begin
            if (dp_done) begin
               nxt_cur.res[`WVRS_HALF_W-1:0] = dp_res;
               if (cur_ff.two) begin
                  nxt_cur.st = wvrs_pkg::sq_hi;
               end else begin
                  nxt_cur.st   = wvrs_pkg::sq_idle;
                  nxt_cur.done = 1'b1;
               end
            end
         end
         // (RULE_10) then the high half
         wvrs_pkg::sq_hi: begin
            if (dp_done) begin
               nxt_cur.res[`WVRS_VEC_W-1:`WVRS_HALF_W] = dp_res;
               nxt_cur.st   = wvrs_pkg::sq_idle;
               nxt_cur.done = 1'b1;
            end
         end
         default: nxt_cur.st = wvrs_pkg::sq_idle;
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end
endmodule : wvrs_div_seq

// [logic/wvrs_pkg.sv]
/*
 Types of the wide vector register state block.
 Assumes wvrs_cfg.svh is on the include path.
*/
`include "wvrs_cfg.svh"
package wvrs_pkg;
   typedef enum logic {enc_legacy, enc_ext} wvrs_enc_t;
   typedef enum logic [2:0] {
      kind_compute, kind_load_op, kind_move_aligned,
      kind_move_unaligned, kind_divsqrt
   } wvrs_kind_t;
   typedef enum logic [1:0] {st_idle, st_penalty, st_div} wvrs_state_t;
   typedef enum logic [1:0] {sq_idle, sq_lo, sq_hi} wvrs_seq_t;
   typedef logic [`WVRS_VEC_W-1:0] wvrs_vec_t;
   typedef logic [`WVRS_IDX_W-1:0] wvrs_idx_t;
endpackage : wvrs_pkg

// [logic/wvrs_top.sv]
/*
 Wide vector register state: sixteen 256-bit registers with a 128-bit
 narrow view, merge and zeroing of results by encoding, register count
 by mode, alignment faults, two-pass divide and the legacy penalty.
 Assumes the execution pipeline supplies results and addresses on the
 core clock, and a 128-bit divide unit outside.
*/
`timescale 1ns/1ps
`include "wvrs_cfg.svh"
module wvrs_top (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // Operating mode
   input  wire logic                     mode64,
   // Request from the pipeline
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  wire wvrs_pkg::wvrs_enc_t      req_enc,
   input  wire logic                     req_len256,
   input  wire wvrs_pkg::wvrs_kind_t     req_kind,
   input  wire logic                     req_mem,
   input  wire logic [63:0]              req_addr,
   input  wire wvrs_pkg::wvrs_idx_t      req_dst,
   input  wire wvrs_pkg::wvrs_idx_t      req_src1,
   input  wire wvrs_pkg::wvrs_idx_t      req_src2,
   input  wire wvrs_pkg::wvrs_vec_t      req_result,
   // Completion
   output logic                          rsp_valid,
   output logic                          rsp_gp_fault,
   output logic                          rsp_reg_fault,
   output logic                          upper_dirty,
   // Read ports
   input  wire wvrs_pkg::wvrs_idx_t      rd_idx_a,
   input  wire wvrs_pkg::wvrs_idx_t      rd_idx_b,
   output wvrs_pkg::wvrs_vec_t           rd_data_a,
   output wvrs_pkg::wvrs_vec_t           rd_data_b,
   // Shared 128-bit divide unit
   output logic                          dp_valid,
   output logic [`WVRS_HALF_W-1:0]       dp_a,
   output logic [`WVRS_HALF_W-1:0]       dp_b,
   input  wire logic                     dp_done,
   input  wire logic [`WVRS_HALF_W-1:0]  dp_res
);
   typedef struct packed {
      wvrs_pkg::wvrs_state_t                        st;
      logic [`WVRS_NREG-1:0][`WVRS_VEC_W-1:0]     regs;
      wvrs_pkg::wvrs_vec_t                          rd_a;
      wvrs_pkg::wvrs_vec_t                          rd_b;
      logic                                         rsp;
      logic                                         gp;
      logic                                         rf;
      logic                                         dirty;
      logic [3:0]                                   pen;
      wvrs_pkg::wvrs_idx_t                          div_dst;
      wvrs_pkg::wvrs_enc_t                          div_enc;
      logic                                         div_len;
   } wvrs_top_state_t;

   wvrs_top_state_t cur_ff;
   wvrs_top_state_t nxt_cur;
   wvrs_div_if      div_link ();

   // Result placement by encoding and length
   function automatic wvrs_pkg::wvrs_vec_t merge_result(
      input wvrs_pkg::wvrs_vec_t old_v,
      input wvrs_pkg::wvrs_vec_t new_v,
      input wvrs_pkg::wvrs_enc_t enc,
      input logic                len256);
      wvrs_pkg::wvrs_vec_t v;
      v = {old_v[`WVRS_VEC_W-1:`WVRS_HALF_W], new_v[`WVRS_HALF_W-1:0]};
      if (enc == wvrs_pkg::enc_ext) begin
         // (RULE_02) full width write
         if (len256) begin
            v = new_v;
         // (RULE_03) upper half zeroed
         end else begin
            v[`WVRS_VEC_W-1:`WVRS_HALF_W] = '0;
         end
      end
      // (RULE_04) legacy keeps the upper half as read above
      return v;
   endfunction : merge_result

   // Register index allowed in the current mode
   function automatic logic idx_ok(input wvrs_pkg::wvrs_idx_t idx,
                                   input logic m64);
      // (RULE_05) eight registers outside 64-bit mode
      return m64 || (idx < `WVRS_IDX_W'(`WVRS_NREG_NARROW));
   endfunction : idx_ok

   // Alignment fault for one memory request
   function automatic logic align_bad(
      input wvrs_pkg::wvrs_enc_t  enc,
      input logic                 len256,
      input wvrs_pkg::wvrs_kind_t kind,
      input logic [63:0]          addr);
      logic bad;
      bad = 1'b0;
      // (RULE_08) legacy memory forms need 16 bytes
      if (enc == wvrs_pkg::enc_legacy) begin
         bad = (addr[`WVRS_NARROW_LSB-1:0] != '0);
      end else if (kind == wvrs_pkg::kind_move_aligned) begin
         // (RULE_06) wide aligned move needs 32 bytes
         if (len256) begin
            bad = (addr[`WVRS_WIDE_LSB-1:0] != '0);
         // (RULE_08) narrow aligned move needs 16 bytes
         end else begin
            bad = (addr[`WVRS_NARROW_LSB-1:0] != '0);
         end
      end
      // (RULE_07) extended load-op and unaligned moves take any address
      return bad;
   endfunction : align_bad

   logic                accept;
   logic                reg_bad;
   logic                gp_bad;
   wvrs_pkg::wvrs_idx_t dst_idx;

   // (RULE_11) legacy after wide code waits; extended waits only outside st_idle
   assign req_ready = (cur_ff.st == wvrs_pkg::st_idle) &&
                      !(cur_ff.dirty && req_enc == wvrs_pkg::enc_legacy);
   assign accept    = req_valid && req_ready;

   // (RULE_09) legacy forms overwrite source one
   assign dst_idx   = (req_enc == wvrs_pkg::enc_legacy) ? req_src1 : req_dst;
   assign reg_bad   = !idx_ok(dst_idx, mode64) ||
                      !idx_ok(req_src1, mode64) ||
                      !idx_ok(req_src2, mode64);
   assign gp_bad    = req_mem &&
                      align_bad(req_enc, req_len256, req_kind, req_addr);

   // Divide operands come straight from the register file
   assign div_link.start    = accept && !reg_bad && !gp_bad &&
                              req_kind == wvrs_pkg::kind_divsqrt;
   assign div_link.two_pass = (req_enc == wvrs_pkg::enc_ext) && req_len256;
   assign div_link.opnd_a   = cur_ff.regs[req_src1];
   assign div_link.opnd_b   = cur_ff.regs[req_src2];

   // Outputs straight from the state
   assign rsp_valid     = cur_ff.rsp;
   assign rsp_gp_fault  = cur_ff.gp;
   assign rsp_reg_fault = cur_ff.rf;
   assign upper_dirty   = cur_ff.dirty;
   assign rd_data_a     = cur_ff.rd_a;
   assign rd_data_b     = cur_ff.rd_b;

   // Next state of the whole block
   always_comb begin
      nxt_cur     = cur_ff;
      nxt_cur.rsp = 1'b0;
      nxt_cur.gp  = 1'b0;
      nxt_cur.rf  = 1'b0;
      // (RULE_01) one store serves both views
      nxt_cur.rd_a = idx_ok(rd_idx_a, mode64) ? cur_ff.regs[rd_idx_a] : '0;
      nxt_cur.rd_b = idx_ok(rd_idx_b, mode64) ? cur_ff.regs[rd_idx_b] : '0;
      unique case (cur_ff.st)
         wvrs_pkg::st_idle: begin
            if (accept) begin
               if (reg_bad || gp_bad) begin
                  // Faulting request leaves the registers alone
                  nxt_cur.rsp = 1'b1;
                  nxt_cur.rf  = reg_bad;
                  nxt_cur.gp  = !reg_bad && gp_bad;
               end else if (req_kind == wvrs_pkg::kind_divsqrt) begin
                  nxt_cur.st      = wvrs_pkg::st_div;
                  nxt_cur.div_dst = dst_idx;
                  nxt_cur.div_enc = req_enc;
                  nxt_cur.div_len = req_len256;
               end else begin
                  nxt_cur.regs[dst_idx] = merge_result(
                     cur_ff.regs[dst_idx], req_result, req_enc, req_len256);
                  nxt_cur.rsp = 1'b1;
               end
               // Wide extended code marks the upper state in use
               if (req_enc == wvrs_pkg::enc_ext && req_len256) begin
                  nxt_cur.dirty = 1'b1;
               end
            end else if (req_valid && cur_ff.dirty &&
                         req_enc == wvrs_pkg::enc_legacy) begin
               // (RULE_11) start the state transition
               nxt_cur.st  = wvrs_pkg::st_penalty;
               nxt_cur.pen = `WVRS_PEN_CYC;
            end
         end
         // (RULE_11) fixed stall, then legacy code runs freely
         wvrs_pkg::st_penalty: begin
            if (cur_ff.pen <= 4'h1) begin
               nxt_cur.st    = wvrs_pkg::st_idle;
               nxt_cur.dirty = 1'b0;
               nxt_cur.pen   = 4'h0;
            end else begin
               nxt_cur.pen = cur_ff.pen - 4'h1;
            end
         end
         // (RULE_10) wait for the last pass, the second one for a wide extended divide
         wvrs_pkg::st_div: begin
            if (div_link.done) begin
               nxt_cur.regs[cur_ff.div_dst] = merge_result(
                  cur_ff.regs[cur_ff.div_dst], div_link.result,
                  cur_ff.div_enc, cur_ff.div_len);
               nxt_cur.rsp = 1'b1;
               nxt_cur.st  = wvrs_pkg::st_idle;
            end
         end
         default: nxt_cur.st = wvrs_pkg::st_idle;
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      // (RULE_12) all register bits clear at reset
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Two-pass divide sequencer
   wvrs_div_seq u_div_seq (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ctl      (div_link.seq),
      .dp_valid (dp_valid),
      .dp_a     (dp_a),
      .dp_b     (dp_b),
      .dp_done  (dp_done),
      .dp_res   (dp_res)
   );
endmodule : wvrs_top

// [test/wvrs_div_model.sv]
/*
 Partner: the shared 128-bit divide unit, answering lat+1 cycles after a request appears.
 Assumes the block holds dp_valid and operands until dp_done.
*/
`timescale 1ns/1ps
module wvrs_div_model (
   // Clock and reset
   input wire logic         core_clk,
   input wire logic         rst_n,
   // Request from the block
   input wire logic         dp_valid,
   input wire logic [127:0] dp_a,
   input wire logic [127:0] dp_b,
   input wire logic [3:0]   lat,
   // Answer
   output logic             dp_done,
   output logic [127:0]     dp_res
);
   logic [3:0] cnt_ff;
   logic       gap_ff;
   // one half per pass
   // Sum stands in for the quotient; a gap edge after each answer
   // keeps a still-held request from counting twice
   always @(posedge core_clk) begin
      dp_done <= 1'b0;
      dp_res  <= ~dp_res; // Released: no stale value
      gap_ff  <= 1'b0;
      if (!rst_n) begin
         cnt_ff <= 4'h0;
         dp_res <= 128'h0;
      end else if (dp_valid && !gap_ff) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (cnt_ff == lat) begin
            dp_done <= 1'b1;
            dp_res  <= dp_a + dp_b;
            cnt_ff  <= 4'h0;
            gap_ff  <= 1'b1;
         end
      end
   end
endmodule : wvrs_div_model

// [test/wvrs_props.sv]
/*
 Checker: fault, stall and divide timing at the register state top.
 Assumes binding into wvrs_top, one core clock domain.
*/
`timescale 1ns/1ps
module wvrs_props (
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   // Request and mode
   input wire logic                 mode64,
   input wire logic                 req_valid,
   input wire logic                 req_ready,
   input wire wvrs_pkg::wvrs_enc_t  req_enc,
   input wire logic                 req_len256,
   input wire wvrs_pkg::wvrs_kind_t req_kind,
   input wire logic                 req_mem,
   input wire logic [63:0]          req_addr,
   input wire wvrs_pkg::wvrs_idx_t  req_dst,
   // Results
   input wire logic                 rsp_valid,
   input wire logic                 rsp_gp_fault,
   input wire logic                 rsp_reg_fault,
   input wire logic                 upper_dirty,
   input wire wvrs_pkg::wvrs_vec_t  rd_data_a,
   input wire logic                 dp_valid
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // Taken request and its class
   wire tk  = req_valid && req_ready;
   wire ext = req_enc == wvrs_pkg::enc_ext;
   wire mva = req_kind == wvrs_pkg::kind_move_aligned;
   wire div = req_kind == wvrs_pkg::kind_divsqrt;
   wire stl = req_valid && !ext && upper_dirty;

   a_wide_move_align: assert property (
      tk && mode64 && ext && req_len256 && mva && req_mem
      && req_addr[4:0] != 5'h0 |=> rsp_valid && rsp_gp_fault)
      else $error("wide aligned move at odd address not faulted");
   a_load_op_free: assert property (
      tk && ext && req_kind == wvrs_pkg::kind_load_op |=> !rsp_gp_fault)
      else $error("load-op request faulted on alignment");
   a_legacy_align: assert property (
      tk && mode64 && !ext && req_mem && req_addr[3:0] != 4'h0
      |=> rsp_gp_fault)
      else $error("legacy access off 16 bytes not faulted");
   a_narrow_move_ok: assert property (
      tk && ext && !req_len256 && mva && req_mem && req_addr[3:0] == 4'h0
      |=> !rsp_gp_fault)
      else $error("aligned narrow move faulted");
   a_reg_limit: assert property (
      tk && !mode64 && ext && req_dst[3] && !div
      |=> rsp_valid && rsp_reg_fault)
      else $error("high register used outside 64-bit mode");
   a_dirty_set: assert property (
      tk && ext && req_len256 |=> upper_dirty)
      else $error("wide request left upper state clean");
   a_legacy_stall: assert property (
      stl |-> !req_ready)
      else $error("legacy request taken over dirty upper state");
   a_penalty_len: assert property (
      $rose(stl) |=> !req_ready [*4])
      else $error("transition penalty shorter than four cycles");
   a_div_start: assert property (
      tk && div |=> (dp_valid && !req_ready) ||
      (rsp_valid && (rsp_gp_fault || rsp_reg_fault)))
      else $error("divide did not start on the shared unit");
   a_reset_clean: assert property (
      $rose(rst_n) |-> !upper_dirty && !rsp_valid && rd_data_a == 256'h0)
      else $error("state not clean after reset");

   // Main scenarios reached
   c_penalty: cover property ($rose(stl) ##5 req_ready);
   c_divide: cover property (tk && div && req_len256);
   c_gp: cover property (rsp_valid && rsp_gp_fault);
   c_reg: cover property (rsp_valid && rsp_reg_fault);
endmodule : wvrs_props

bind wvrs_top wvrs_props u_props (.core_clk, .rst_n, .mode64, .req_valid,
   .req_ready, .req_enc, .req_len256, .req_kind, .req_mem, .req_addr,
   .req_dst, .rsp_valid, .rsp_gp_fault, .rsp_reg_fault, .upper_dirty,
   .rd_data_a, .dp_valid);

// [test/wvrs_tb_top.sv]
/*
 Bench: drives the register state top, checks responses and reads.
 Assumes the checker is bound and the divide model answers.
*/
`timescale 1ns/1ps
module wvrs_tb_top;
   localparam wvrs_pkg::wvrs_enc_t  ext = wvrs_pkg::enc_ext;
   localparam wvrs_pkg::wvrs_enc_t  leg = wvrs_pkg::enc_legacy;
   localparam wvrs_pkg::wvrs_kind_t k_cmp = wvrs_pkg::kind_compute;
   localparam wvrs_pkg::wvrs_kind_t k_ld = wvrs_pkg::kind_load_op;
   localparam wvrs_pkg::wvrs_kind_t k_mva = wvrs_pkg::kind_move_aligned;
   localparam wvrs_pkg::wvrs_kind_t k_mvu = wvrs_pkg::kind_move_unaligned;
   localparam wvrs_pkg::wvrs_kind_t k_div = wvrs_pkg::kind_divsqrt;
   logic                 core_clk, rst_n, mode64, req_valid, req_ready;
   logic                 req_len256, req_mem, rsp_valid, rsp_gp_fault;
   logic                 rsp_reg_fault, upper_dirty, dp_valid, dp_done;
   wvrs_pkg::wvrs_enc_t  req_enc;
   wvrs_pkg::wvrs_kind_t req_kind;
   logic [63:0]          req_addr;
   wvrs_pkg::wvrs_idx_t  req_dst, req_src1, req_src2, rd_idx_a, rd_idx_b;
   wvrs_pkg::wvrs_vec_t  req_result, rd_data_a, rd_data_b, va, vb, vc;
   logic [127:0]         dp_a, dp_b, dp_res;
   logic [3:0]           lat;
   logic [1:0]           exp_q[$];
   int                   fails, tests_run, seed, w;

   wvrs_top uut (.core_clk, .rst_n, .mode64, .req_valid, .req_ready,
      .req_enc, .req_len256, .req_kind, .req_mem, .req_addr, .req_dst,
      .req_src1, .req_src2, .req_result, .rsp_valid, .rsp_gp_fault,
      .rsp_reg_fault, .upper_dirty, .rd_idx_a, .rd_idx_b, .rd_data_a,
      .rd_data_b, .dp_valid, .dp_a, .dp_b, .dp_done, .dp_res);
   wvrs_div_model u_dm (.core_clk, .rst_n, .dp_valid, .dp_a, .dp_b, .lat,
      .dp_done, .dp_res);

   // Core clock, 100 ns
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [255:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   function automatic wvrs_pkg::wvrs_vec_t rnd;
      wvrs_pkg::wvrs_vec_t v;
      for (int j = 0; j < 8; j++)
         v[j*32 +: 32] = $random(seed);
      return v;
   endfunction : rnd

   // Hold the request until an edge takes it; w counts refused cycles
   task automatic issue(input wvrs_pkg::wvrs_enc_t e, input logic l,
         input wvrs_pkg::wvrs_kind_t k, input logic [63:0] a,
         input wvrs_pkg::wvrs_idx_t d, s, input wvrs_pkg::wvrs_vec_t r,
         input logic [1:0] ex);
      req_valid = 1'b1;
      req_enc = e;
      req_len256 = l;
      req_kind = k;
      req_mem = |a;
      req_addr = a;
      req_dst = d;
      req_src1 = s;
      req_result = r;
      #1;
      for (w = 0; req_ready !== 1'b1; w++) begin
         if (w == 20) begin
            fails++;
            end_of_test();
         end
         @(posedge core_clk) #1;
      end
      @(posedge core_clk);
      exp_q.push_back(ex);
      #1;
   endtask : issue

   // Release the request and wait for every noted response
   task automatic settle;
      req_valid = 1'b0;
      for (int i = 0; exp_q.size() != 0; i++) begin
         if (i == 60) begin
            fails++;
            end_of_test();
         end
         @(posedge core_clk) #1;
      end
   endtask : settle

   task automatic rd(input wvrs_pkg::wvrs_idx_t i,
         input wvrs_pkg::wvrs_vec_t ex);
      rd_idx_a = i;
      rd_idx_b = i;
      @(posedge core_clk) #1;
      check("rd_data_a", rd_data_a, ex);
      check("rd_data_b", rd_data_b, ex);
   endtask : rd

   // Random address with a chosen low part; faulting cases aim at reg 6
   task automatic align(input wvrs_pkg::wvrs_enc_t e, input logic l,
         input wvrs_pkg::wvrs_kind_t k, input logic [4:0] o, input logic g);
      logic [63:0] a;
      a = {$random(seed), $random(seed)};
      a[4:0] = o;
      a[63] = 1'b1;
      issue(e, l, k, a, g ? 4'h6 : 4'h7, g ? 4'h6 : 4'h7, rnd(), {g, 1'b0});
   endtask : align

   // Each completion takes the oldest note
   always @(posedge core_clk)
      if (rst_n === 1'b1 && rsp_valid !== 1'b0)
         if (exp_q.size() == 0)
            check("rsp_valid", rsp_valid, 256'h0);
         else
            check("rsp_fault", {rsp_gp_fault, rsp_reg_fault},
               exp_q.pop_front());

   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      end_of_test();
   end

   // Main sequence
   initial begin
      seed = 32'h15ca;
      fails = 0;
      tests_run = 0;
      {rst_n, mode64, req_valid, req_len256, req_mem} = 5'h08;
      req_enc = leg;
      req_kind = k_cmp;
      {req_addr, lat} = 68'h0;
      {req_dst, req_src1, req_src2, rd_idx_a, rd_idx_b} = 20'h0;
      req_result = 256'h0;
      repeat (6) @(posedge core_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 16; i++)
         rd(4'(i), 256'h0);
      va = rnd();
      vb = rnd();
      vc = rnd();
      issue(ext, 1'b1, k_cmp, 64'h0, 4'h3, 4'h0, va, 2'h0);
      issue(ext, 1'b0, k_cmp, 64'h0, 4'h4, 4'h3, vb, 2'h0);
      check("ext_wait", w, 256'h0);
      issue(ext, 1'b1, k_cmp, 64'h0, 4'hc, 4'h0, vc, 2'h0);
      issue(leg, 1'b0, k_cmp, 64'h0, 4'h9, 4'h3, vc, 2'h0);
      check("legacy_wait", w, 256'h5);
      settle();
      rd(4'h3, {va[255:128], vc[127:0]});
      rd(4'h4, {128'h0, vb[127:0]});
      rd(4'hc, vc);
      rd(4'h9, 256'h0);
      mode64 = 1'b0;
      rd(4'hc, 256'h0);
      issue(ext, 1'b0, k_cmp, 64'h0, 4'ha, 4'h0, vb, 2'h1);
      issue(ext, 1'b0, k_cmp, 64'h0, 4'h2, 4'h0, vb, 2'h0);
      settle();
      mode64 = 1'b1;
      rd(4'ha, 256'h0);
      rd(4'h2, {128'h0, vb[127:0]});
      align(ext, 1'b1, k_mva, 5'h10, 1'b1);
      align(ext, 1'b1, k_mva, 5'h00, 1'b0);
      align(ext, 1'b1, k_ld, 5'h03, 1'b0);
      align(ext, 1'b0, k_ld, 5'h11, 1'b0);
      align(ext, 1'b1, k_mvu, 5'h01, 1'b0);
      align(ext, 1'b0, k_mva, 5'h08, 1'b1);
      align(ext, 1'b0, k_mva, 5'h10, 1'b0);
      align(leg, 1'b0, k_cmp, 5'h04, 1'b1);
      align(leg, 1'b0, k_ld, 5'h10, 1'b0);
      settle();
      rd(4'h6, 256'h0);
      req_src2 = 4'hc;
      lat = 4'h3;
      issue(ext, 1'b1, k_div, 64'h0, 4'hd, 4'h3, 256'h0, 2'h0);
      settle();
      lat = 4'h0;
      issue(ext, 1'b0, k_div, 64'h0, 4'he, 4'h3, 256'h0, 2'h0);
      settle();
      rd(4'hd, {va[255:128] + vc[255:128], vc[127:0] + vc[127:0]});
      rd(4'he, {128'h0, vc[127:0] + vc[127:0]});
      end_of_test();
   end
endmodule : wvrs_tb_top
